// [resolver_fault_and_position_status_tb.sv]
// Self-checking testbench of the resolver fault and position status bank.
module resolver_fault_and_position_status_tb;
  timeunit 1ns;
  timeprecision 1ns;

  // Bit position in the fault register of each synchroniser lane.
  localparam int POS_OF [12] = '{15, 14, 12, 11, 10, 6, 5, 4, 3, 2, 1, 0};

  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic regRead;
  logic [7:0] regAddr;
  logic [15:0] readData;
  logic readValid;
  // Asynchronous fault and pin levels, one lane each.
  logic [11:0] asyncIn = 12'h000;
  // Self-test pulses: diag exit, logic pass, logic fail, analog pass, analog fail.
  logic [4:0] coreIn = 5'h00;
  logic serialCommFault = 1'b0;
  logic [1:0] exciterModeSetting = 2'h0;
  logic analogSelftestRunning = 1'b0;
  logic [13:0] parallelOutputWord = 14'h0000;
  logic parallelOutputClock = 1'b0;
  logic [11:0] angleValue = 12'h000;
  logic [11:0] velocityValue = 12'h000;
  logic resolution12 = 1'b0;
  int miscompares = 0;
  int checksDone = 0;
  logic [15:0] d;
  logic [13:0] v;

  // Free-running core clock, 40 ns period.
  always #20 ref_clk = ~ref_clk;

  rfs_status_bank dut_u (
    .ref_clk(ref_clk), .reset(reset), .regRead(regRead), .regAddr(regAddr),
    .readData(readData), .readValid(readValid),
    .exciterHighFault(asyncIn[rfs_pkg::SYNC_EXC_HIGH]),
    .exciterLowFault(asyncIn[rfs_pkg::SYNC_EXC_LOW]),
    .boostOvervoltage(asyncIn[rfs_pkg::SYNC_BOOST_OV]),
    .digitalRegulatorOvercurrent(asyncIn[rfs_pkg::SYNC_VDD_OC]),
    .exciterThermalWarning(asyncIn[rfs_pkg::SYNC_THERMAL]),
    .mainSupplyOvervoltage(asyncIn[rfs_pkg::SYNC_VCC_OV]),
    .digitalSupplyOvervoltage(asyncIn[rfs_pkg::SYNC_VDD_OV]),
    .pinMismatchFault(asyncIn[rfs_pkg::SYNC_PIN_MISMATCH]),
    .faultPinLevel(asyncIn[rfs_pkg::SYNC_FAULT_PIN]),
    .encoderALevel(asyncIn[rfs_pkg::SYNC_ENC_A]),
    .encoderBLevel(asyncIn[rfs_pkg::SYNC_ENC_B]),
    .encoderZLevel(asyncIn[rfs_pkg::SYNC_ENC_Z]),
    .serialCommFault(serialCommFault), .exciterModeSetting(exciterModeSetting),
    .analogSelftestFail(coreIn[0]), .analogSelftestPass(coreIn[1]),
    .analogSelftestRunning(analogSelftestRunning), .diagnosticExitCommand(coreIn[4]),
    .logicSelftestFail(coreIn[2]), .logicSelftestPass(coreIn[3]),
    .parallelOutputWord(parallelOutputWord), .parallelOutputClock(parallelOutputClock),
    .angleValue(angleValue), .velocityValue(velocityValue), .resolution12(resolution12)
  );

  rfs_host_model host_u (
    .ref_clk(ref_clk), .regRead(regRead), .regAddr(regAddr),
    .readData(readData), .readValid(readValid)
  );

  // Counts a comparison and reports a mismatch at once.
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    checksDone++;
    if (seen !== want) begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check

  // Reads one register and confirms that the answer was flagged valid.
  task automatic rd(input logic [7:0] addr, output logic [15:0] data);
    logic valid;
    host_u.doRead(addr, data, valid);
    check({15'h0000, valid}, 16'h0001);
  endtask : rd

  // Waits a number of falling edges.
  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : idle

  // Gives the self-test inputs a one-cycle pulse.
  task automatic pulse(input logic [4:0] p);
    @(negedge ref_clk);
    coreIn = p;
    @(negedge ref_clk);
    coreIn = 5'h00;
  endtask : pulse

  // Expected angle image from the tracking-loop values.
  function automatic logic [15:0] expAngle();
    logic [11:0] a;
    a = resolution12 ? angleValue : {2'b00, angleValue[9:0]};
    return {1'b0, ^parallelOutputWord, parallelOutputClock, 1'b0, a};
  endfunction : expAngle

  // Expected velocity field, sign-extended from the sign bit of the resolution.
  function automatic logic [13:0] expVel();
    if (resolution12) return {{2{velocityValue[11]}}, velocityValue};
    return {{4{velocityValue[9]}}, velocityValue[9:0]};
  endfunction : expVel

  // Prints the verdict and ends the run.
  task automatic tally_and_finish();
    if (miscompares == 0 && checksDone > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish

  // Cuts a hang short well after the tests should have ended.
  initial begin
    #(40 * 20000);
    miscompares++;
    tally_and_finish();
  end

  // Main sequence of scenarios.
  initial begin
    void'($urandom(73));
    repeat (10) @(posedge ref_clk);
    @(negedge ref_clk);
    reset = 1'b0;
    // Every register and an unmapped offset read zero after reset.
    for (int a = 16; a < 20; a++) begin
      rd(a[7:0], d);
      check(d, 16'h0000);
    end
    // Each fault lane: sticky flags survive the fault, a read clears them; fault pin, encoder A and B levels are live.
    for (int l = 0; l < 12; l++) begin
      @(negedge ref_clk);
      asyncIn[l] = 1'b1;
      idle(8);
      if (l >= 8 && l <= 10) begin
        rd(8'h10, d);
        check(d, 16'h0001 << POS_OF[l]);
        rd(8'h10, d);
        check(d, 16'h0001 << POS_OF[l]);
      end
      asyncIn[l] = 1'b0;
      idle(8);
      if (!(l >= 8 && l <= 10)) begin
        rd(8'h10, d);
        check(d, 16'h0001 << POS_OF[l]);
      end
      rd(8'h10, d);
      check(d, 16'h0000);
    end
    // Serial fault pulse arriving with a read: old value returned, flag kept.
    fork
      rd(8'h10, d);
      begin
        @(negedge ref_clk);
        serialCommFault = 1'b1;
        @(negedge ref_clk);
        serialCommFault = 1'b0;
      end
    join
    check(d, 16'h0000);
    rd(8'h10, d);
    check(d, 16'h2000);
    rd(8'h10, d);
    check(d, 16'h0000);
    // Serial fault held into a read: the read sees it, the lingering level sets it again.
    @(negedge ref_clk);
    serialCommFault = 1'b1;
    rd(8'h10, d);
    serialCommFault = 1'b0;
    check(d, 16'h2000);
    rd(8'h10, d);
    check(d, 16'h2000);
    rd(8'h10, d);
    check(d, 16'h0000);
    // Every exciter mode code.
    for (int m = 0; m < 4; m++) begin
      exciterModeSetting = m[1:0];
      rd(8'h10, d);
      check(d, (m != 0) ? 16'h0200 : 16'h0000);
    end
    exciterModeSetting = 2'h0;
    // Self-test flags: reads leave them, a pass clears, a fail beats a pass.
    pulse(5'h01);
    rd(8'h10, d);
    rd(8'h10, d);
    check(d, 16'h0100);
    pulse(5'h02);
    rd(8'h10, d);
    check(d, 16'h0000);
    pulse(5'h04);
    pulse(5'h03);
    rd(8'h10, d);
    rd(8'h10, d);
    check(d, 16'h0180);
    pulse(5'h08);
    rd(8'h10, d);
    check(d, 16'h0100);
    pulse(5'h0c);
    rd(8'h10, d);
    check(d, 16'h0180);
    pulse(5'h08);
    pulse(5'h02);
    pulse(5'h10);
    rd(8'h10, d);
    check(d, 16'h0000);
    analogSelftestRunning = 1'b1;
    pulse(5'h10);
    analogSelftestRunning = 1'b0;
    rd(8'h10, d);
    check(d, 16'h0100);
    pulse(5'h02);
    // Random output words with corner values first.
    for (int i = 0; i < 60; i++) begin
      @(negedge ref_clk);
      parallelOutputWord = 14'($urandom);
      parallelOutputClock = 1'($urandom);
      angleValue = (i < 2) ? 12'hfff : 12'($urandom);
      velocityValue = (i == 0) ? 12'h200 : (i == 1) ? 12'h800 : 12'($urandom);
      resolution12 = (i < 2) ? i[0] : 1'($urandom);
      idle(int'($urandom_range(0, 2)));
      rd(8'h11, d);
      check(d, expAngle());
      rd(8'h12, d);
      check(d, {1'b0, ^parallelOutputWord, expVel()});
      v = host_u.velocityOf(d, resolution12);
      check({2'b00, v}, {2'b00, expVel()});
      rd(8'h13, d);
      check(d, 16'h0000);
    end
    tally_and_finish();
  end
endmodule : resolver_fault_and_position_status_tb

// [rfs_flag_bank.sv]
// Clear-on-read sticky flag bank with set priority over clear.
module rfs_flag_bank (
  input wire logic ref_clk,
  input wire logic reset,
  rfs_flag_if.bank flagBus
);

  // All state of the bank.
  typedef struct packed {
    logic [rfs_pkg::COR_W-1:0] flags;
  } rfs_bank_s;

  rfs_bank_s state;
  rfs_bank_s next_state;

  // A clear drops every flag, but a set in the same cycle survives it.
  always_comb begin
    next_state = state;
    if (flagBus.clearAll) begin
      next_state.flags = '0;
    end
    next_state.flags = next_state.flags | flagBus.setEvents;
  end

  // The flag register, cleared by power-on reset.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign flagBus.flags = state.flags;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  // A set request always shows in the flag one cycle later, clear or not.
  a_set_wins_clear: assert property ((flagBus.setEvents != '0) |=>
    ((flagBus.flags & $past(flagBus.setEvents)) == $past(flagBus.setEvents)))
    else $error("flag set lost against a clear");

  // A clear with no set empties the bank.
  a_clear_empties: assert property ((flagBus.clearAll && flagBus.setEvents == '0) |=>
    (flagBus.flags == '0))
    else $error("flags not cleared by a read");

endmodule : rfs_flag_bank

// [rfs_flag_if.sv]
// Carrier between the status bank and its clear-on-read flag bank.
interface rfs_flag_if;

  // Flag set requests, one lane per flag.
  logic [rfs_pkg::COR_W-1:0] setEvents;
  // One-cycle request to clear every flag.
  logic clearAll;
  // Present flag values.
  logic [rfs_pkg::COR_W-1:0] flags;

  // The flag bank keeps the flags.
  modport bank (input setEvents, input clearAll, output flags);
  // The status bank requests and reads them.
  modport owner (output setEvents, output clearAll, input flags);

endinterface : rfs_flag_if

// [rfs_host_model.sv]
// Host microcontroller model that reads the status bank through its read port.
module rfs_host_model (
  input wire logic ref_clk,
  output logic regRead,
  output logic [7:0] regAddr,
  input wire logic [15:0] readData,
  input wire logic readValid
);
  timeunit 1ns;
  timeprecision 1ns;

  // The port starts idle with no request pending.
  initial begin
    regRead = 1'b0;
    regAddr = 8'h00;
  end

  // One read: the request stands for one edge, the answer is taken on the next edge.
  task automatic doRead(input logic [7:0] addr, output logic [15:0] data, output logic valid);
    @(negedge ref_clk);
    regRead = 1'b1;
    regAddr = addr;
    @(negedge ref_clk);
    regRead = 1'b0;
    // The address is no longer qualified, so it carries a changed pattern.
    regAddr = ~addr;
    data = readData;
    valid = readValid;
  endtask : doRead

  // Velocity as the host sees it: bits above the sign of the chosen resolution are dropped.
  function automatic logic [13:0] velocityOf(input logic [15:0] data, input logic res12);
    return res12 ? {{2{data[11]}}, data[11:0]} : {{4{data[9]}}, data[9:0]};
  endfunction : velocityOf
endmodule : rfs_host_model

// [rfs_pkg.sv]
// Shared constants of the resolver fault and position status bank.
package rfs_pkg;

  // Register offsets; the read port addresses registers directly.
  localparam logic [7:0] ADDR_FAULT_STATUS = 8'h10;
  localparam logic [7:0] ADDR_ANGLE_STATUS = 8'h11;
  localparam logic [7:0] ADDR_VELOCITY_STATUS = 8'h12;

  // Reset value of every register and of the read data.
  localparam logic [15:0] REG_RESET = 16'h0000;

  // Bit positions in the supply and exciter fault status register.
  localparam int ST_EXC_HIGH = 15;
  localparam int ST_EXC_LOW = 14;
  localparam int ST_SERIAL = 13;
  localparam int ST_BOOST_OV = 12;
  localparam int ST_VDD_OC = 11;
  localparam int ST_THERMAL = 10;
  localparam int ST_EXC_DISABLED = 9;
  localparam int ST_ANALOG_BIST = 8;
  localparam int ST_LOGIC_BIST = 7;
  localparam int ST_VCC_OV = 6;
  localparam int ST_VDD_OV = 5;
  localparam int ST_PIN_MISMATCH = 4;
  localparam int ST_FAULT_PIN = 3;
  localparam int ST_ENC_A = 2;
  localparam int ST_ENC_B = 1;
  localparam int ST_ENC_Z = 0;

  // Field positions in the angle and velocity status registers.
  localparam int POS_PARITY = 14;
  localparam int POS_OUT_CLOCK = 13;
  localparam int ANGLE_MSB = 12;
  localparam int VELOCITY_MSB = 13;

  // Lanes of the input synchroniser vector.
  localparam int SYNC_EXC_HIGH = 0;
  localparam int SYNC_EXC_LOW = 1;
  localparam int SYNC_BOOST_OV = 2;
  localparam int SYNC_VDD_OC = 3;
  localparam int SYNC_THERMAL = 4;
  localparam int SYNC_VCC_OV = 5;
  localparam int SYNC_VDD_OV = 6;
  localparam int SYNC_PIN_MISMATCH = 7;
  localparam int SYNC_FAULT_PIN = 8;
  localparam int SYNC_ENC_A = 9;
  localparam int SYNC_ENC_B = 10;
  localparam int SYNC_ENC_Z = 11;
  localparam int SYNC_W = 12;

  // Lanes of the clear-on-read flag bank.
  localparam int COR_EXC_HIGH = 0;
  localparam int COR_EXC_LOW = 1;
  localparam int COR_SERIAL = 2;
  localparam int COR_BOOST_OV = 3;
  localparam int COR_VDD_OC = 4;
  localparam int COR_THERMAL = 5;
  localparam int COR_VCC_OV = 6;
  localparam int COR_VDD_OV = 7;
  localparam int COR_PIN_MISMATCH = 8;
  localparam int COR_ENC_Z = 9;
  localparam int COR_W = 10;

  // Exciter mode setting that keeps the exciter running; any other code disables it.
  localparam logic [1:0] EXC_MODE_ENABLED = 2'h0;

endpackage : rfs_pkg

// [rfs_status_bank.sv]
// Resolver fault, angle and velocity status registers with their read port.
module rfs_status_bank (
  input wire logic ref_clk,
  input wire logic reset,
  // Read request from the serial interface, one cycle.
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  // Read answer, one cycle after the request.
  output logic [15:0] readData,
  output logic readValid,
  // Analog fault comparators, asynchronous to the core clock.
  input wire logic exciterHighFault,
  input wire logic exciterLowFault,
  input wire logic boostOvervoltage,
  input wire logic digitalRegulatorOvercurrent,
  input wire logic exciterThermalWarning,
  input wire logic mainSupplyOvervoltage,
  input wire logic digitalSupplyOvervoltage,
  input wire logic pinMismatchFault,
  // Pin levels read back from the pads, asynchronous.
  input wire logic faultPinLevel,
  input wire logic encoderALevel,
  input wire logic encoderBLevel,
  input wire logic encoderZLevel,
  // Core logic signals on the same clock.
  input wire logic serialCommFault,
  input wire logic [1:0] exciterModeSetting,
  input wire logic analogSelftestFail,
  input wire logic analogSelftestPass,
  input wire logic analogSelftestRunning,
  input wire logic diagnosticExitCommand,
  input wire logic logicSelftestFail,
  input wire logic logicSelftestPass,
  // Parallel output path of the tracking loop.
  input wire logic [13:0] parallelOutputWord,
  input wire logic parallelOutputClock,
  input wire logic [11:0] angleValue,
  input wire logic [11:0] velocityValue,
  input wire logic resolution12
);

  // All state of the status bank.
  typedef struct packed {
    logic [rfs_pkg::SYNC_W-1:0] stage1;
    logic [rfs_pkg::SYNC_W-1:0] stage2;
    logic [rfs_pkg::SYNC_W-1:0] stage3;
    logic [rfs_pkg::SYNC_W-1:0] level;
    logic analogFault;
    logic logicFault;
    logic [15:0] readData;
    logic readValid;
  } rfs_state_s;

  // Right-justifies the angle for the selected resolution.
  function automatic logic [12:0] fmtAngle(input logic [11:0] a, input logic res12);
    logic [12:0] r;
    r = 13'h0000;
    if (res12) begin
      r = {1'b0, a};
    end else begin
      r = {3'h0, a[9:0]};
    end
    return r;
  endfunction : fmtAngle

  // Sign-extends the velocity from the sign bit of the selected resolution.
  function automatic logic [13:0] fmtVelocity(input logic [11:0] v, input logic res12);
    logic [13:0] r;
    r = 14'h0000;
    if (res12) begin
      r = {{2{v[11]}}, v};
    end else begin
      r = {{4{v[9]}}, v[9:0]};
    end
    return r;
  endfunction : fmtVelocity

  rfs_state_s state;
  rfs_state_s next_state;
  // Raw asynchronous inputs gathered into one vector.
  logic [rfs_pkg::SYNC_W-1:0] rawInputs;
  // Assembled register images.
  logic [15:0] faultImage;
  logic [15:0] angleImage;
  logic [15:0] velocityImage;
  // A taken read of the fault status register.
  logic faultRead;
  // Even parity over the parallel output word.
  logic outputParity;

  // Link to the clear-on-read flags.
  rfs_flag_if flagBus ();

  rfs_flag_bank flagBank (
    .ref_clk(ref_clk),
    .reset(reset),
    .flagBus(flagBus)
  );

  // Gather the asynchronous inputs in lane order.
  always_comb begin
    rawInputs = '0;
    rawInputs[rfs_pkg::SYNC_EXC_HIGH] = exciterHighFault;
    rawInputs[rfs_pkg::SYNC_EXC_LOW] = exciterLowFault;
    rawInputs[rfs_pkg::SYNC_BOOST_OV] = boostOvervoltage;
    rawInputs[rfs_pkg::SYNC_VDD_OC] = digitalRegulatorOvercurrent;
    rawInputs[rfs_pkg::SYNC_THERMAL] = exciterThermalWarning;
    rawInputs[rfs_pkg::SYNC_VCC_OV] = mainSupplyOvervoltage;
    rawInputs[rfs_pkg::SYNC_VDD_OV] = digitalSupplyOvervoltage;
    rawInputs[rfs_pkg::SYNC_PIN_MISMATCH] = pinMismatchFault;
    rawInputs[rfs_pkg::SYNC_FAULT_PIN] = faultPinLevel;
    rawInputs[rfs_pkg::SYNC_ENC_A] = encoderALevel;
    rawInputs[rfs_pkg::SYNC_ENC_B] = encoderBLevel;
    rawInputs[rfs_pkg::SYNC_ENC_Z] = encoderZLevel;
  end

  // A read of the fault register clears its clear-on-read flags.
  assign faultRead = regRead && (regAddr == rfs_pkg::ADDR_FAULT_STATUS);
  assign flagBus.clearAll = faultRead;

  // Filtered levels and the serial fault drive the sticky flags; set requests hold while a fault lasts.
  always_comb begin
    flagBus.setEvents = '0;
    flagBus.setEvents[rfs_pkg::COR_EXC_HIGH] = state.level[rfs_pkg::SYNC_EXC_HIGH];
    flagBus.setEvents[rfs_pkg::COR_EXC_LOW] = state.level[rfs_pkg::SYNC_EXC_LOW];
    flagBus.setEvents[rfs_pkg::COR_SERIAL] = serialCommFault;
    flagBus.setEvents[rfs_pkg::COR_BOOST_OV] = state.level[rfs_pkg::SYNC_BOOST_OV];
    flagBus.setEvents[rfs_pkg::COR_VDD_OC] = state.level[rfs_pkg::SYNC_VDD_OC];
    flagBus.setEvents[rfs_pkg::COR_THERMAL] = state.level[rfs_pkg::SYNC_THERMAL];
    flagBus.setEvents[rfs_pkg::COR_VCC_OV] = state.level[rfs_pkg::SYNC_VCC_OV];
    flagBus.setEvents[rfs_pkg::COR_VDD_OV] = state.level[rfs_pkg::SYNC_VDD_OV];
    flagBus.setEvents[rfs_pkg::COR_PIN_MISMATCH] = state.level[rfs_pkg::SYNC_PIN_MISMATCH];
    flagBus.setEvents[rfs_pkg::COR_ENC_Z] = state.level[rfs_pkg::SYNC_ENC_Z];
  end

  // Assemble the fault status image from flags, self-test bits and pin levels.
  always_comb begin
    faultImage = rfs_pkg::REG_RESET;
    faultImage[rfs_pkg::ST_EXC_HIGH] = flagBus.flags[rfs_pkg::COR_EXC_HIGH];
    faultImage[rfs_pkg::ST_EXC_LOW] = flagBus.flags[rfs_pkg::COR_EXC_LOW];
    faultImage[rfs_pkg::ST_SERIAL] = flagBus.flags[rfs_pkg::COR_SERIAL];
    faultImage[rfs_pkg::ST_BOOST_OV] = flagBus.flags[rfs_pkg::COR_BOOST_OV];
    faultImage[rfs_pkg::ST_VDD_OC] = flagBus.flags[rfs_pkg::COR_VDD_OC];
    faultImage[rfs_pkg::ST_THERMAL] = flagBus.flags[rfs_pkg::COR_THERMAL];
    // The disabled indication follows the mode setting live.
    faultImage[rfs_pkg::ST_EXC_DISABLED] =
      (exciterModeSetting != rfs_pkg::EXC_MODE_ENABLED);
    faultImage[rfs_pkg::ST_ANALOG_BIST] = state.analogFault;
    faultImage[rfs_pkg::ST_LOGIC_BIST] = state.logicFault;
    faultImage[rfs_pkg::ST_VCC_OV] = flagBus.flags[rfs_pkg::COR_VCC_OV];
    faultImage[rfs_pkg::ST_VDD_OV] = flagBus.flags[rfs_pkg::COR_VDD_OV];
    faultImage[rfs_pkg::ST_PIN_MISMATCH] = flagBus.flags[rfs_pkg::COR_PIN_MISMATCH];
    faultImage[rfs_pkg::ST_FAULT_PIN] = state.level[rfs_pkg::SYNC_FAULT_PIN];
    faultImage[rfs_pkg::ST_ENC_A] = state.level[rfs_pkg::SYNC_ENC_A];
    faultImage[rfs_pkg::ST_ENC_B] = state.level[rfs_pkg::SYNC_ENC_B];
    faultImage[rfs_pkg::ST_ENC_Z] = flagBus.flags[rfs_pkg::COR_ENC_Z];
  end

  // Parity is taken over the full word on the parallel output pins.
  assign outputParity = ^parallelOutputWord;

  // Assemble the angle and velocity images; bit 15 of each is reserved zero.
  always_comb begin
    angleImage = rfs_pkg::REG_RESET;
    angleImage[rfs_pkg::POS_PARITY] = outputParity;
    angleImage[rfs_pkg::POS_OUT_CLOCK] = parallelOutputClock;
    angleImage[rfs_pkg::ANGLE_MSB:0] = fmtAngle(angleValue, resolution12);
    velocityImage = rfs_pkg::REG_RESET;
    velocityImage[rfs_pkg::POS_PARITY] = outputParity;
    // Bits above the sign carry its copy; the host does not rely on them.
    velocityImage[rfs_pkg::VELOCITY_MSB:0] = fmtVelocity(velocityValue, resolution12);
  end

  // Next-state logic: synchronisers, self-test flags and the read answer.
  always_comb begin
    next_state = state;
    // Three-stage synchroniser; a lane changes once stages two and three agree.
    next_state.stage1 = rawInputs;
    next_state.stage2 = state.stage1;
    next_state.stage3 = state.stage2;
    for (int i = 0; i < rfs_pkg::SYNC_W; i++) begin
      if (state.stage2[i] == state.stage3[i]) begin
        next_state.level[i] = state.stage3[i];
      end
    end
    // Analog self-test flag: a pass clears it, a failure or early exit wins.
    if (analogSelftestPass) begin
      next_state.analogFault = 1'b0;
    end
    if (analogSelftestFail) begin
      next_state.analogFault = 1'b1;
    end
    if (diagnosticExitCommand && analogSelftestRunning) begin
      next_state.analogFault = 1'b1;
    end
    // Logic self-test flag: a pass clears it unless a failure comes with it.
    if (logicSelftestPass) begin
      next_state.logicFault = 1'b0;
    end
    if (logicSelftestFail) begin
      next_state.logicFault = 1'b1;
    end
    // The answer captures the image before any clear takes effect.
    next_state.readValid = regRead;
    if (regRead) begin
      case (regAddr)
        rfs_pkg::ADDR_FAULT_STATUS: begin
          next_state.readData = faultImage;
        end
        rfs_pkg::ADDR_ANGLE_STATUS: begin
          next_state.readData = angleImage;
        end
        rfs_pkg::ADDR_VELOCITY_STATUS: begin
          next_state.readData = velocityImage;
        end
        default: begin
          // Unmapped offsets answer with zero.
          next_state.readData = rfs_pkg::REG_RESET;
        end
      endcase
    end
  end

  // State register, cleared by power-on reset.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign readData = state.readData;
  assign readValid = state.readValid;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  // A filtered high fault lands in its sticky flag on the next cycle.
  a_exc_high_set: assert property (state.level[rfs_pkg::SYNC_EXC_HIGH] |=>
    flagBus.flags[rfs_pkg::COR_EXC_HIGH])
    else $error("exciter high fault not latched");

  // A fault register read with no pending low fault clears that flag.
  a_exc_low_clear: assert property ((faultRead &&
    !state.level[rfs_pkg::SYNC_EXC_LOW]) |=> !flagBus.flags[rfs_pkg::COR_EXC_LOW])
    else $error("exciter low flag survived its read");

  // A serial fault one cycle before a fault register read reads back set.
  a_serial_flag_read: assert property ((serialCommFault ##1 faultRead) |=>
    (readValid && readData[rfs_pkg::ST_SERIAL]))
    else $error("serial fault missing from read");

  // The disabled bit answers the mode setting seen at the read.
  a_exc_disabled_bit: assert property (faultRead |=>
    (readData[rfs_pkg::ST_EXC_DISABLED] ==
    ($past(exciterModeSetting) != rfs_pkg::EXC_MODE_ENABLED)))
    else $error("exciter disabled bit wrong");

  // The analog self-test fault is not cleared by reads, only by a pass.
  a_analog_sticky: assert property ((state.analogFault && !analogSelftestPass) |=>
    state.analogFault)
    else $error("analog self-test fault dropped");

  // An exit while the analog self-test runs raises its fault.
  a_diag_exit_set: assert property ((diagnosticExitCommand &&
    analogSelftestRunning) |=> state.analogFault)
    else $error("diagnostic exit did not flag self-test");

  // A clean logic self-test pass clears its fault.
  a_logic_pass_clear: assert property ((logicSelftestPass && !logicSelftestFail) |=>
    !state.logicFault)
    else $error("logic self-test fault not cleared");

  // Angle parity is the XOR of the word at the read.
  a_angle_parity: assert property ((regRead &&
    regAddr == rfs_pkg::ADDR_ANGLE_STATUS) |=>
    (readData[rfs_pkg::POS_PARITY] == ^$past(parallelOutputWord)))
    else $error("angle parity wrong");

  // In ten-bit resolution angle bits 12 to 10 read zero.
  a_angle_ten_bit: assert property ((regRead && !resolution12 &&
    regAddr == rfs_pkg::ADDR_ANGLE_STATUS) |=> (readData[12:10] == 3'h0))
    else $error("angle high bits not zero in ten-bit mode");

  // Ten-bit velocity copies bit 9 into bits 13 to 10.
  a_velocity_sign: assert property ((regRead && !resolution12 &&
    regAddr == rfs_pkg::ADDR_VELOCITY_STATUS) |=> (readData[13:10] == {4{readData[9]}}))
    else $error("velocity sign extension wrong");

  // A clearing read returns the exciter high flag that was set before it.
  a_read_old_value: assert property ((faultRead &&
    flagBus.flags[rfs_pkg::COR_EXC_HIGH]) |=> readData[rfs_pkg::ST_EXC_HIGH])
    else $error("read lost the value before clearing");

  // A filtered thermal warning lands in its sticky flag on the next cycle.
  a_thermal_set: assert property (state.level[rfs_pkg::SYNC_THERMAL] |=>
    flagBus.flags[rfs_pkg::COR_THERMAL])
    else $error("thermal warning not latched");

  // A logic self-test failure always raises its fault, pass or not.
  a_logic_fail_set: assert property (logicSelftestFail |=> state.logicFault)
    else $error("logic self-test fault not set");

  // The fault pin bit reads the filtered pin level seen at the read.
  a_fault_pin_live: assert property (faultRead |=>
    (readData[rfs_pkg::ST_FAULT_PIN] == $past(state.level[rfs_pkg::SYNC_FAULT_PIN])))
    else $error("fault pin monitor wrong");

  // The reserved top bit and the top bit of the angle field always read zero.
  a_angle_top_zero: assert property ((regRead &&
    regAddr == rfs_pkg::ADDR_ANGLE_STATUS) |=>
    (!readData[15] && !readData[rfs_pkg::ANGLE_MSB]))
    else $error("angle top bits not zero");

  // The angle register shows the output clock level seen at the read.
  a_angle_out_clock: assert property ((regRead &&
    regAddr == rfs_pkg::ADDR_ANGLE_STATUS) |=>
    (readData[rfs_pkg::POS_OUT_CLOCK] == $past(parallelOutputClock)))
    else $error("output clock bit wrong");

  // Main scenarios: a flagged read, an early exit, a negative velocity.
  c_flag_read: cover property (faultRead && flagBus.flags != '0);
  c_diag_exit: cover property (diagnosticExitCommand && analogSelftestRunning);
  c_neg_velocity: cover property (regRead && resolution12 && velocityValue[11] &&
    regAddr == rfs_pkg::ADDR_VELOCITY_STATUS);

endmodule : rfs_status_bank
